// File: inc/lsd_pkg.sv
// package of constants, types and mapping defaults for the segment display driver
package lsd_pkg;

    // ************************************************************
    // geometry and build options
    // ************************************************************
    localparam int LSD_SEGS    = 38;
    localparam int LSD_COMS    = 4;
    localparam int LSD_PAIRS   = 19;
    localparam int LSD_MEM_WDS = 38;

    // ************************************************************
    // register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [9:0] LSD_IDX_BLANK = 10'h2D0;
    localparam logic [9:0] LSD_IDX_DRIVE = 10'h2E8;
    localparam logic [9:0] LSD_IDX_PAGE0 = 10'h040;
    localparam logic [9:0] LSD_IDX_PAGE2 = 10'h240;

    // field positions inside the drive register
    localparam int LSD_DRV_STATIC_BIT = 3;
    localparam int LSD_DRV_MASK_MSB   = 2;

    // values after reset
    localparam logic       LSD_RST_BLANK  = 1'b1;
    localparam logic       LSD_RST_STATIC = 1'b0;
    localparam logic [2:0] LSD_RST_TMASK  = 3'h0;

    // ************************************************************
    // frame timing, in oscillator periods per frame
    // ************************************************************
    localparam int LSD_FRAME_DIV4   = 1024;
    localparam int LSD_FRAME_DIV3   = 768;
    localparam int LSD_FRAME_STATIC = 1024;

    // ************************************************************
    // drive level codes and bus answers
    // ************************************************************
    localparam logic [1:0] LSD_LV_VSS = 2'h0;
    localparam logic [1:0] LSD_LV_C1  = 2'h1;
    localparam logic [1:0] LSD_LV_C2  = 2'h2;
    localparam logic [1:0] LSD_LV_C3  = 2'h3;
    localparam logic [1:0] LSD_RESP_OKAY   = 2'h0;
    localparam logic [1:0] LSD_RESP_SLVERR = 2'h2;

    // one display memory bit seen by a segment in one common slot
    typedef struct packed {
        logic [5:0] word;
        logic [1:0] bitSel;
    } lsd_map_s;

    typedef lsd_map_s [LSD_SEGS-1:0][LSD_COMS-1:0] lsd_map_t;

    // axi4-lite request and answer bundles
    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } lsd_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } lsd_axi_rsp_s;

    // default mapping: segment s, common c reads word s, bit c
    function automatic lsd_map_t lsd_default_map();
        lsd_map_t m;
        for (int s = 0; s < LSD_SEGS; s++) begin
            for (int c = 0; c < LSD_COMS; c++) begin
                m[s][c].word   = 6'(s);
                m[s][c].bitSel = 2'(c);
            end
        end
        return m;
    endfunction : lsd_default_map

endpackage : lsd_pkg

// File: rtl/lsd_segment_driver.sv
// multiplexed segment display driver with axi4-lite register and display memory access
//
// The implementer's own choice: the AXI4-Lite register port.
module lsd_segment_driver
    import lsd_pkg::*;
#(
    parameter int              DUTY_COMS  = 4,
    parameter bit              HALF_BIAS  = 1'b0,
    parameter bit              PAGE_TWO   = 1'b0,
    parameter lsd_map_t        SEG_MAP    = lsd_default_map(),
    parameter logic [18:0]     DC_PAIRS   = 19'h0,
    parameter logic [37:0]     OPEN_DRAIN = 38'h0
) (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic                  lowOscTick,
    input  wire lsd_axi_req_s          axiReq,
    output lsd_axi_rsp_s               axiRsp,
    output logic [LSD_COMS-1:0][1:0]   commonOutputs,
    output logic [LSD_SEGS-1:0][1:0]   segmentOutputs,
    output logic [LSD_SEGS-1:0]        segmentOe
);

    // ************************************************************
    // timing constants derived from the frame divisors
    // ************************************************************
    // a 1/3 duty frame spreads 768 ticks over three slots and 1/4 duty spreads 1024 over
    // four, so both share a 256-tick slot; two-common scanning (512) and static drive (1024) need longer ones
    localparam logic [9:0] SLOT_END_DYN = 10'(LSD_FRAME_DIV3 / 3 - 1);
    localparam logic [9:0] SLOT_END_TWO = 10'(LSD_FRAME_DIV4 / 2 - 1);
    localparam logic [9:0] SLOT_END_STA = 10'(LSD_FRAME_STATIC - 1);
    localparam logic [1:0] LAST_SLOT    = 2'(DUTY_COMS - 1);
    localparam logic [9:0] MEM_BASE     = PAGE_TWO ? LSD_IDX_PAGE2 : LSD_IDX_PAGE0;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic                      awHeld;
        logic [11:0]               awAddr;
        logic                      wHeld;
        logic [31:0]               wData;
        logic [3:0]                wStrb;
        lsd_axi_rsp_s              rsp;
        logic                      blankCtl;
        logic                      staticSel;
        logic [2:0]                timerMask;
        logic                      effBlank;
        logic                      effStatic;
        logic [9:0]                divCnt;
        logic [1:0]                slot;
        logic                      pol;
        logic [LSD_COMS-1:0][1:0]  comLvl;
        logic [LSD_SEGS-1:0][1:0]  segLvl;
        logic [LSD_SEGS-1:0]       segOe;
    } lsd_state_s;

    lsd_state_s         s_r;
    lsd_state_s         s_nxt;
    logic [3:0]         dispMem [LSD_MEM_WDS];
    logic               memWe;
    logic [5:0]         memIdx;
    logic [3:0]         memData;

    // true when a word index falls in the display memory window
    function automatic logic isMem(input logic [9:0] idx);
        return (idx >= MEM_BASE) && (idx < MEM_BASE + 10'(LSD_MEM_WDS));
    endfunction : isMem

    // half bias has only one middle level, so c2 folds onto c1
    function automatic logic [1:0] fold(input logic [1:0] lv);
        return (HALF_BIAS && lv == LSD_LV_C2) ? LSD_LV_C1 : lv;
    endfunction : fold

    // ************************************************************
    // register decode
    // ************************************************************
    // register targets that one word index can select
    typedef enum {
        TGT_NONE,
        TGT_BLANK,
        TGT_DRIVE,
        TGT_MEM
    } lsd_tgt_e;

    // one decode serves both channels, so reads and writes agree on the map
    function automatic lsd_tgt_e decodeIdx(input logic [9:0] idx);
        lsd_tgt_e t;
        t = TGT_NONE;
        if (idx == LSD_IDX_BLANK) begin
            t = TGT_BLANK;
        end else if (idx == LSD_IDX_DRIVE) begin
            t = TGT_DRIVE;
        end else if (isMem(idx)) begin
            t = TGT_MEM;
        end
        return t;
    endfunction : decodeIdx

    // last tick count of a slot; static drive uses one long slot per frame
    function automatic logic [9:0] slotEndFor(input logic staticMode);
        logic [9:0] e;
        e = SLOT_END_DYN;
        if (staticMode) begin
            e = SLOT_END_STA;
        end else if (DUTY_COMS == 2) begin
            e = SLOT_END_TWO;
        end
        return e;
    endfunction : slotEndFor

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic [9:0]  wIdx;
        logic [9:0]  rIdx;
        logic [9:0]  slotEnd;
        logic        lit;
        logic [3:0]  bits;
        wIdx    = '0;
        rIdx    = '0;
        slotEnd = '0;
        lit     = 1'b0;
        bits    = '0;
        s_nxt   = s_r;
        memWe   = 1'b0;
        memIdx  = '0;
        memData = '0;

        // ********************************
        // bus channels
        // ********************************
        // write address and data are taken in either order
        if (axiReq.awvalid && s_r.rsp.awready) begin
            s_nxt.awHeld = 1'b1;
            s_nxt.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && s_r.rsp.wready) begin
            s_nxt.wHeld = 1'b1;
            s_nxt.wData = axiReq.wdata;
            s_nxt.wStrb = axiReq.wstrb;
        end
        if (s_r.rsp.bvalid && axiReq.bready) begin
            s_nxt.rsp.bvalid = 1'b0;
        end
        // perform the write once both halves are held
        // held copies come from next state, so halves arriving together write at once
        if (s_nxt.awHeld && s_nxt.wHeld && !s_nxt.rsp.bvalid) begin
            wIdx             = s_nxt.awAddr[11:2];
            s_nxt.awHeld     = 1'b0;
            s_nxt.wHeld      = 1'b0;
            s_nxt.rsp.bvalid = 1'b1;
            s_nxt.rsp.bresp  = LSD_RESP_OKAY;
            unique case (decodeIdx(wIdx))
                TGT_BLANK: begin
                    if (s_nxt.wStrb[0]) begin
                        s_nxt.blankCtl = s_nxt.wData[0];
                    end
                end
                TGT_DRIVE: begin
                    if (s_nxt.wStrb[0]) begin
                        s_nxt.staticSel = s_nxt.wData[LSD_DRV_STATIC_BIT];
                        s_nxt.timerMask = s_nxt.wData[LSD_DRV_MASK_MSB:0];
                    end
                end
                TGT_MEM: begin
                    // display memory write in the chosen page
                    memWe   = s_nxt.wStrb[0];
                    memIdx  = 6'(wIdx - MEM_BASE);
                    memData = s_nxt.wData[3:0];
                end
                TGT_NONE: begin
                    s_nxt.rsp.bresp = LSD_RESP_SLVERR;
                end
            endcase
        end
        // a pending answer holds off both halves, keeping one write in flight
        s_nxt.rsp.awready = !s_nxt.awHeld && !s_nxt.rsp.bvalid;
        s_nxt.rsp.wready  = !s_nxt.wHeld && !s_nxt.rsp.bvalid;

        // read channel: one read outstanding, answered next cycle
        // read data comes from registered state, so a same-cycle write is not yet seen
        if (s_r.rsp.rvalid && axiReq.rready) begin
            s_nxt.rsp.rvalid  = 1'b0;
            s_nxt.rsp.arready = 1'b1;
        end else if (axiReq.arvalid && s_r.rsp.arready) begin
            rIdx              = axiReq.araddr[11:2];
            s_nxt.rsp.arready = 1'b0;
            s_nxt.rsp.rvalid  = 1'b1;
            s_nxt.rsp.rdata   = '0;
            s_nxt.rsp.rresp   = LSD_RESP_OKAY;
            unique case (decodeIdx(rIdx))
                TGT_BLANK: begin
                    s_nxt.rsp.rdata[0] = s_r.blankCtl;
                end
                TGT_DRIVE: begin
                    s_nxt.rsp.rdata[LSD_DRV_STATIC_BIT] = s_r.staticSel;
                    s_nxt.rsp.rdata[LSD_DRV_MASK_MSB:0] = s_r.timerMask;
                end
                TGT_MEM: begin
                    // page 2 memory reads as zero, write only
                    if (!PAGE_TWO) begin
                        s_nxt.rsp.rdata[3:0] = dispMem[6'(rIdx - MEM_BASE)];
                    end
                end
                TGT_NONE: begin
                    s_nxt.rsp.rresp = LSD_RESP_SLVERR;
                end
            endcase
        end

        // ********************************
        // scan timing
        // ********************************
        // slot length from duty and frame divisor
        slotEnd = slotEndFor(s_r.effStatic);
        // the tick must be one clock wide; a longer pulse would count twice
        if (lowOscTick) begin
            if (s_r.divCnt >= slotEnd) begin
                s_nxt.divCnt = '0;
                // ascending scan, polarity flips each frame
                if (s_r.effStatic || s_r.slot >= LAST_SLOT) begin
                    s_nxt.slot = '0;
                    s_nxt.pol  = !s_r.pol;
                end else begin
                    s_nxt.slot = s_r.slot + 2'h1;
                end
                // control bits adopted only at a slot boundary
                s_nxt.effBlank  = s_r.blankCtl;
                s_nxt.effStatic = s_r.staticSel;
            end else begin
                s_nxt.divCnt = s_r.divCnt + 10'h1;
            end
        end

        // ********************************
        // pin waveforms
        // ********************************
        // common waveforms; unused commons stay unselected except under static drive, which selects all four
        for (int c = 0; c < LSD_COMS; c++) begin
            if (s_nxt.effStatic || 2'(c) == s_nxt.slot) begin
                s_nxt.comLvl[c] = s_nxt.pol ? LSD_LV_VSS : LSD_LV_C3;
            end else begin
                // middle level folded under half bias
                s_nxt.comLvl[c] = fold(s_nxt.pol ? LSD_LV_C2 : LSD_LV_C1);
            end
        end

        // segment waveforms, one per terminal
        for (int g = 0; g < LSD_SEGS; g++) begin
            // a map entry past the last memory word reads unknown, so tables must stay in range
            // mapped display bits for each common
            for (int c = 0; c < LSD_COMS; c++) begin
                bits[c] = dispMem[SEG_MAP[g][c].word][SEG_MAP[g][c].bitSel];
            end
            s_nxt.segOe[g] = 1'b1;
            if (DC_PAIRS[g/2]) begin
                // dc terminal drives its common-0 bit
                lit = bits[0] && s_nxt.effBlank;
                s_nxt.segLvl[g] = lit ? LSD_LV_C3 : LSD_LV_VSS;
                // open-drain only drives the high level
                if (OPEN_DRAIN[g]) begin
                    s_nxt.segOe[g] = lit;
                end
            end else begin
                // static drive lights on any common's bit
                lit = s_nxt.effStatic ? (|bits) : bits[s_nxt.slot];
                lit = lit && s_nxt.effBlank;
                // a set bit gives the opposite extreme to the common
                if (lit) begin
                    s_nxt.segLvl[g] = s_nxt.pol ? LSD_LV_C3 : LSD_LV_VSS;
                end else if (s_nxt.effStatic) begin
                    s_nxt.segLvl[g] = s_nxt.pol ? LSD_LV_VSS : LSD_LV_C3;
                end else begin
                    // off level sits at the middle potential
                    s_nxt.segLvl[g] = fold(s_nxt.pol ? LSD_LV_C1 : LSD_LV_C2);
                end
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    // control state, bus answers and pin levels
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r             <= '0;
            s_r.rsp.awready <= 1'b1;
            s_r.rsp.wready  <= 1'b1;
            s_r.rsp.arready <= 1'b1;
            s_r.blankCtl    <= LSD_RST_BLANK;
            s_r.effBlank    <= LSD_RST_BLANK;
            s_r.staticSel   <= LSD_RST_STATIC;
            s_r.effStatic   <= LSD_RST_STATIC;
            s_r.timerMask   <= LSD_RST_TMASK;
            s_r.segOe       <= '1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // display memory has no reset, contents undefined until written
    always_ff @(posedge clk) begin
        if (memWe) begin
            dispMem[memIdx] <= memData;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // an open-drain dc terminal lets go by dropping its enable; its level code drops to vss
    // four commons and 38 segments, all straight from flops
    assign axiRsp         = s_r.rsp;
    assign commonOutputs  = s_r.comLvl;
    assign segmentOutputs = s_r.segLvl;
    assign segmentOe      = s_r.segOe;

endmodule : lsd_segment_driver

// File: tb/lsd_chk.sv
// assertion checker on the ports of the segment display driver
module lsd_chk
    import lsd_pkg::*;
#(
    parameter logic [18:0] DC_PAIRS   = 19'h0,
    parameter logic [37:0] OPEN_DRAIN = 38'h0
) (
    input wire logic             clk,
    input wire logic             nrst,
    input wire logic             lowOscTick,
    input wire lsd_axi_req_s     axiReq,
    input wire lsd_axi_rsp_s     axiRsp,
    input wire logic [3:0][1:0]  commonOutputs,
    input wire logic [37:0][1:0] segmentOutputs,
    input wire logic [37:0]      segmentOe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] tickHist_r;
    logic [2:0] evtHist_r;
    logic [1:0] upCnt_r;
    logic [1:0] memCnt_r;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // recent ticks and writes; pins may only move shortly after one
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tickHist_r <= 3'h0;
            evtHist_r  <= 3'h0;
            upCnt_r    <= 2'h0;
            memCnt_r   <= 2'h0;
        end else begin
            tickHist_r <= {tickHist_r[1:0], lowOscTick};
            evtHist_r  <= {evtHist_r[1:0], lowOscTick | axiRsp.bvalid};
            upCnt_r    <= (upCnt_r == 2'h3) ? upCnt_r : upCnt_r + 2'h1;
            // dc pair 0 reads memory word 0, which reset leaves unknown; wait for its write
            if (memCnt_r != 2'h0 || (axiReq.awvalid && axiRsp.awready
                    && axiReq.awaddr[11:2] inside {LSD_IDX_PAGE0, LSD_IDX_PAGE2})) begin
                memCnt_r <= (memCnt_r == 2'h3) ? memCnt_r : memCnt_r + 2'h1;
            end
        end
    end

    // ********
    // bus
    // ********
    wr_answer_a: assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid
        && axiRsp.wready |=> axiRsp.bvalid) else $error("write not answered");
    b_hold_a: assert property (axiRsp.bvalid && !axiReq.bready
        |=> axiRsp.bvalid && $stable(axiRsp.bresp)) else $error("write answer dropped");
    b_drop_a: assert property (axiRsp.bvalid && axiReq.bready |=> !axiRsp.bvalid)
        else $error("write answer repeated");
    aw_block_a: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
        else $error("write taken while answer pending");
    rd_answer_a: assert property (axiReq.arvalid && axiRsp.arready
        |=> axiRsp.rvalid && !axiRsp.arready) else $error("read not answered");
    r_hold_a: assert property (axiRsp.rvalid && !axiReq.rready
        |=> axiRsp.rvalid && $stable(axiRsp.rdata)) else $error("read data moved");

    // ********
    // panel pins
    // ********
    com_slot_a: assert property (upCnt_r == 2'h3 && !$stable(commonOutputs)
        |-> |tickHist_r) else $error("commons moved off a slot boundary");
    seg_slot_a: assert property (upCnt_r == 2'h3 && !$stable(segmentOutputs)
        |-> |evtHist_r) else $error("segments moved without cause");
    dc_level_a: assert property (DC_PAIRS[0] && memCnt_r == 2'h3
        |-> segmentOutputs[0] inside {2'h0, 2'h3}) else $error("dc terminal at a middle level");
    oe_push_a: assert property (&(segmentOe | OPEN_DRAIN))
        else $error("push-pull terminal released");

    cover property (axiRsp.bvalid && axiRsp.bresp == LSD_RESP_SLVERR);
    cover property (axiRsp.rvalid && !axiReq.rready);
    cover property (upCnt_r == 2'h3 && !$stable(commonOutputs));
endmodule : lsd_chk

bind lsd_segment_driver lsd_chk #(.DC_PAIRS(DC_PAIRS), .OPEN_DRAIN(OPEN_DRAIN)) chk (
    .clk(clk), .nrst(nrst), .lowOscTick(lowOscTick), .axiReq(axiReq), .axiRsp(axiRsp),
    .commonOutputs(commonOutputs), .segmentOutputs(segmentOutputs), .segmentOe(segmentOe));

// File: tb/lsd_panel.sv
// passive panel model recording which cells it saw lit per common
module lsd_panel
    import lsd_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             clear,
    input  wire logic [3:0][1:0]  commonOutputs,
    input  wire logic [37:0][1:0] segmentOutputs,
    output logic [37:0][3:0]      seenLit
);
    timeunit 1ns;
    timeprecision 1ps;

    // a cell lights only at full swing: selected common against opposite segment level
    // full swing decode
    always @(posedge clk) begin
        for (int c = 0; c < 4; c++) begin
            for (int s = 0; s < 38; s++) begin
                if (clear)
                    seenLit[s][c] <= 1'b0;
                else if (commonOutputs[c] inside {2'h0, 2'h3})
                    seenLit[s][c] <= seenLit[s][c] | (commonOutputs[c] === ~segmentOutputs[s]);
            end
        end
    end
endmodule : lsd_panel

// File: tb/tb.sv
// self-checking bench for the segment display driver
module tb
    import lsd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK_DIV = 4;
    localparam int SLOT     = 256 * TICK_DIV;

    logic             clk        = 1'b0;
    logic             nrst       = 1'b0;
    logic             lowOscTick = 1'b0;
    logic             clearLit   = 1'b1;
    lsd_axi_req_s     axiReq     = '{wstrb: 4'hF, default: '0};
    lsd_axi_rsp_s     axiRsp;
    logic [3:0][1:0]  commonOutputs;
    logic [37:0][1:0] segmentOutputs;
    logic [37:0]      segmentOe;
    logic [37:0][3:0] seenLit;
    logic [37:0][3:0] expLit;
    int               mismatches = 0;
    int               num_checks = 0;
    int               cycleCnt   = 0;

    // pair 0 as dc outputs, segment 1 open drain
    lsd_segment_driver #(.DC_PAIRS(19'h1), .OPEN_DRAIN(38'h2)) DUT (
        .clk(clk), .nrst(nrst), .lowOscTick(lowOscTick), .axiReq(axiReq), .axiRsp(axiRsp),
        .commonOutputs(commonOutputs), .segmentOutputs(segmentOutputs), .segmentOe(segmentOe));
    lsd_panel panel (.clk(clk), .clear(clearLit), .commonOutputs(commonOutputs),
        .segmentOutputs(segmentOutputs), .seenLit(seenLit));

    always #2 clk = ~clk;

    // oscillator tick every fourth clock keeps frames short; also the hang limit
    always @(posedge clk) begin
        cycleCnt <= cycleCnt + 1;
        lowOscTick <= (cycleCnt % TICK_DIV == TICK_DIV - 1);
        if (cycleCnt == 80000) begin
            mismatches++;
            summarize();
        end
    end

    function automatic logic [3:0] pat(input int s);
        return 4'(s * 7 + 1);
    endfunction : pat

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // ********
    // bus tasks: bready and rready come late so the slave must hold its answer
    // ********
    task automatic axiWrite(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        axiReq.awaddr <= a;
        axiReq.wdata <= d;
        axiReq.awvalid <= 1'b1;
        axiReq.wvalid <= 1'b1;
        axiReq.bready <= 1'b0;
        do begin
            @(posedge clk);
            if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
            if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
            if (!axiReq.awvalid && !axiReq.wvalid && !axiReq.bready) axiReq.bready <= 1'b1;
        end while (!(axiRsp.bvalid && axiReq.bready));
        r = axiRsp.bresp;
    endtask : axiWrite

    task automatic axiRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        axiReq.araddr <= a;
        axiReq.arvalid <= 1'b1;
        axiReq.rready <= 1'b0;
        do begin
            @(posedge clk);
            if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
            else if (!axiReq.arvalid && !axiReq.rready) axiReq.rready <= 1'b1;
        end while (!(axiRsp.rvalid && axiReq.rready));
        d = axiRsp.rdata;
        r = axiRsp.rresp;
    endtask : axiRead

    // cycles between two successive changes of the commons
    task automatic slotLen(output int len);
        logic [3:0][1:0] prev;
        len = 0;
        prev = commonOutputs;
        while (commonOutputs === prev) @(posedge clk);
        prev = commonOutputs;
        while (commonOutputs === prev) begin
            @(posedge clk);
            len++;
        end
    endtask : slotLen

    // let settings land, then watch one whole frame; pair 0 is dc and skipped
    task automatic litCheck();
        repeat (SLOT + 100) @(posedge clk);
        clearLit <= 1'b1;
        @(posedge clk);
        clearLit <= 1'b0;
        repeat (4 * SLOT + 100) @(posedge clk);
        for (int s = 2; s < 38; s++) begin
            check(32'(seenLit[s]), 32'(expLit[s]));
        end
    endtask : litCheck

    task automatic summarize();
        if (mismatches == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        int          len;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        axiRead(12'hB40, d, r);
        check(d, 32'h1);
        axiRead(12'hBA0, d, r);
        check(d, 32'h0);
        axiRead(12'h000, d, r);
        check({d[29:0], r}, 32'(LSD_RESP_SLVERR));
        axiWrite(12'h000, 32'h1, r);
        check(32'(r), 32'(LSD_RESP_SLVERR));
        axiWrite(12'hBA0, 32'h7, r);
        axiRead(12'hBA0, d, r);
        check(d, 32'h7);
        axiWrite(12'hBA0, 32'h0, r);
        // fill the page 0 memory with a distinct pattern
        for (int s = 0; s < 38; s++) begin
            axiWrite(12'h100 + 12'(4 * s), 32'(pat(s)), r);
            expLit[s] = pat(s);
        end
        check(32'(r), 32'(LSD_RESP_OKAY));
        axiRead(12'h114, d, r);
        check(d, 32'(pat(5)));
        slotLen(len);
        check(32'(len), 32'(SLOT));
        litCheck();
        check(32'(segmentOutputs[0]), 32'h3);
        check(32'(segmentOe[1:0]), 32'h1);
        // blanking keeps memory but darkens everything
        axiWrite(12'hB40, 32'h0, r);
        axiRead(12'hB40, d, r);
        check(d, 32'h0);
        expLit = '0;
        litCheck();
        axiWrite(12'hB40, 32'h1, r);
        axiRead(12'h114, d, r);
        check(d, 32'(pat(5)));
        // static drive with equal data in every common
        axiWrite(12'hBA0, 32'h8, r);
        axiRead(12'hBA0, d, r);
        check(d, 32'h8);
        for (int s = 0; s < 38; s++) begin
            expLit[s] = s[0] ? 4'hF : 4'h0;
            axiWrite(12'h100 + 12'(4 * s), 32'(expLit[s]), r);
        end
        slotLen(len);
        check(32'(len), 32'(4 * SLOT));
        litCheck();
        axiWrite(12'hBA0, 32'h0, r);
        slotLen(len);
        check(32'(len), 32'(SLOT));
        summarize();
    end
endmodule : tb
